// File: logic/isbr_host.sv
// Host sequencer that drives start reservation, joining and bus recovery
`timescale 1ns/10ps
module isbr_host
  import isbr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  // User command port
  input  wire logic       cmd_valid_in,
  input  wire isbr_cmd_t  cmd_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       mode_resv_disable_in,
  input  wire logic       mode_start_wo_stop_in,
  input  wire logic       mode_poll_in,
  input  wire logic [7:0] low_width_in,
  input  wire logic [7:0] high_width_in,
  output logic            cmd_ready_out,
  output logic            cmd_done_out,
  output isbr_res_t       cmd_result_out,
  // Interrupt capture
  output logic            irq_seen_out,
  output logic            irq_master_out,
  output logic [7:0]      irq_status_out,
  output logic [7:0]      irq_flags_out,
  // Device side
  input  wire isbr_stat_t dev_stat_in,
  output isbr_ctrl_t      dev_ctrl_out,
  // Clock pin override for recovery
  output logic            scl_out,
  output logic            scl_oe_n_out
);

  typedef enum {
    ST_IDLE, ST_CFG1, ST_ENABLE, ST_TRIG_CLEAR, ST_JOIN_WAIT, ST_FREE_WAIT,
    ST_START_TRIG, ST_START_CHECK, ST_RESV_WAIT, ST_RECOV_LO, ST_RECOV_HI, ST_DONE
  } isbr_state_t;

  isbr_state_t        state_reg;
  isbr_stat_t         stat;
  logic [CNT_W-1:0]   cnt_reg;
  logic [PULSE_W-1:0] pulse_reg;
  logic [7:0]         addr_reg;
  logic               irq_prev_reg;
  logic [CNT_W-1:0]   check_wait;

  // Reservation check wait in clocks, synchroniser lag included
  function automatic logic [CNT_W-1:0] resv_wait(input logic [7:0] lo, input logic [7:0] hi);
    resv_wait = CNT_W'(lo) + CNT_W'(hi) + CNT_W'(WAIT_EXTRA_CLK + 2 * FALL_CLK + SYNC_STAGES);
  endfunction

  assign check_wait = resv_wait(low_width_in, high_width_in);

  isbr_sync #(
    .W($bits(isbr_stat_t))
  ) u_sync (
    .clock_in  (clock_in),
    .reset_n_in(reset_n_in),
    .d_in      (dev_stat_in),
    .q_out     (stat)
  );

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_reg      <= ST_IDLE;
      dev_ctrl_out   <= '0;
      cnt_reg        <= '0;
      pulse_reg      <= '0;
      addr_reg       <= 8'h00;
      cmd_ready_out  <= 1'b1;
      cmd_done_out   <= 1'b0;
      cmd_result_out <= RES_OK;
      scl_out        <= 1'b1;
      scl_oe_n_out   <= 1'b1;
    end else begin
      // Triggers and strobes last one cycle
      cmd_done_out                  <= 1'b0;
      dev_ctrl_out.start_trigger    <= 1'b0;
      dev_ctrl_out.stop_trigger     <= 1'b0;
      dev_ctrl_out.bus_release_exit <= 1'b0;
      dev_ctrl_out.ctrl1_write      <= 1'b0;
      dev_ctrl_out.shift_write      <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          if (cmd_valid_in) begin
            cmd_ready_out  <= 1'b0;
            cmd_result_out <= RES_OK;
            case (cmd_in)
              CMD_INIT: begin
                dev_ctrl_out.i2c_enable_bit            <= 1'b0;
                dev_ctrl_out.reservation_disable       <= mode_resv_disable_in;
                dev_ctrl_out.start_without_stop_enable <= mode_start_wo_stop_in;
                state_reg                              <= ST_CFG1;
              end
              CMD_JOIN: begin
                dev_ctrl_out.stop_interrupt_enable <= 1'b0;
                dev_ctrl_out.i2c_enable_bit        <= 1'b1;
                state_reg                          <= ST_JOIN_WAIT;
              end
              CMD_START: begin
                dev_ctrl_out.stop_interrupt_enable <= !mode_poll_in;
                addr_reg                           <= cmd_data_in;
                state_reg                          <= ST_START_TRIG;
              end
              CMD_STOP: begin
                dev_ctrl_out.stop_trigger <= 1'b1;
                state_reg                 <= ST_TRIG_CLEAR;
              end
              CMD_WRITE: begin
                dev_ctrl_out.shift_write <= 1'b1;
                dev_ctrl_out.shift_data  <= cmd_data_in;
                state_reg                <= ST_DONE;
              end
              CMD_FREE_CHECK: begin
                state_reg <= ST_FREE_WAIT;
              end
              default: begin
                pulse_reg <= '0;
                state_reg <= ST_RECOV_LO;
              end
            endcase
          end
        end
        ST_CFG1: begin
          dev_ctrl_out.ctrl1_write <= 1'b1;
          state_reg                <= ST_ENABLE;
        end
        ST_ENABLE: begin
          dev_ctrl_out.i2c_enable_bit <= 1'b1;
          if (dev_ctrl_out.start_without_stop_enable) begin
            // busy flag reads clear, check lines
            state_reg <= ST_FREE_WAIT;
          end else begin
            dev_ctrl_out.stop_trigger <= 1'b1;
            state_reg                 <= ST_TRIG_CLEAR;
          end
        end
        ST_TRIG_CLEAR: begin
          // hold off until device clears trigger
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg > CNT_W'(SYNC_STAGES) && !stat.start_trigger_pending && !stat.stop_trigger_pending) begin
            state_reg <= ST_DONE;
          end
        end
        ST_JOIN_WAIT: begin
          // exit after start detect, before ack
          cnt_reg <= cnt_reg + 1'b1;
          if (stat.start_detected_flag) begin
            dev_ctrl_out.bus_release_exit <= 1'b1;
            state_reg                     <= ST_DONE;
          end else if (cnt_reg == CNT_W'(JOIN_ACK_MAX_CLK)) begin
            cmd_result_out <= RES_TIMEOUT;
            state_reg      <= ST_DONE;
          end
        end
        ST_FREE_WAIT: begin
          // both lines high for one frame
          if (stat.clock_line_level && stat.data_line_level) begin
            cnt_reg <= cnt_reg + 1'b1;
          end else begin
            cnt_reg <= '0;
          end
          if (cnt_reg == CNT_W'(BUS_FREE_CLK - 1) && stat.clock_line_level && stat.data_line_level) begin
            state_reg <= ST_DONE;
          end
        end
        ST_START_TRIG: begin
          if (!stat.start_trigger_pending && !stat.stop_trigger_pending) begin
            dev_ctrl_out.start_trigger <= 1'b1;
            cnt_reg                    <= '0;
            state_reg                  <= ST_START_CHECK;
          end
        end
        ST_START_CHECK: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (dev_ctrl_out.reservation_disable) begin
            // read fail flag after its settle time
            if (cnt_reg == CNT_W'(START_FAIL_WAIT_CLK + SYNC_STAGES)) begin
              cmd_result_out <= stat.start_fail_flag ? RES_REJECTED : RES_OK;
              state_reg      <= ST_DONE;
            end
          end else if (cnt_reg == check_wait) begin
            if (stat.master_status_flag) begin
              dev_ctrl_out.shift_write <= 1'b1;
              dev_ctrl_out.shift_data  <= addr_reg;
              state_reg                <= ST_DONE;
            end else begin
              cmd_result_out <= RES_RESERVED;
              cmd_done_out   <= 1'b1;
              state_reg      <= ST_RESV_WAIT;
            end
          end
        end
        ST_RESV_WAIT: begin
          // address only after stop irq or, in poll mode, master flag
          if ((stat.i2c_interrupt && stat.stop_detected_flag) || (mode_poll_in && stat.master_status_flag)) begin
            dev_ctrl_out.shift_write <= 1'b1;
            dev_ctrl_out.shift_data  <= addr_reg;
            cmd_result_out           <= RES_RESV_DONE;
            state_reg                <= ST_DONE;
          end
        end
        ST_RECOV_LO: begin
          scl_out      <= 1'b0;
          scl_oe_n_out <= 1'b0;
          cnt_reg      <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RECOV_HALF_CLK - 1)) begin
            cnt_reg   <= '0;
            pulse_reg <= pulse_reg + 1'b1;
            state_reg <= ST_RECOV_HI;
          end
        end
        ST_RECOV_HI: begin
          // Releasing lets the pull-up make the high phase
          scl_out      <= 1'b1;
          scl_oe_n_out <= 1'b1;
          cnt_reg      <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RECOV_HALF_CLK - 1)) begin
            cnt_reg <= '0;
            if (stat.serial_data_pin) begin
              state_reg <= ST_DONE;
            end else if (pulse_reg == PULSE_W'(RECOV_MAX_PULSES)) begin
              cmd_result_out <= RES_TIMEOUT;
              state_reg      <= ST_DONE;
            end else begin
              state_reg <= ST_RECOV_LO;
            end
          end
        end
        default: begin
          cmd_done_out  <= 1'b1;
          cmd_ready_out <= 1'b1;
          state_reg     <= ST_IDLE;
        end
      endcase
    end
  end

  // Latch arbitration result and status at each interrupt
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      irq_prev_reg   <= 1'b0;
      irq_seen_out   <= 1'b0;
      irq_master_out <= 1'b0;
      irq_status_out <= 8'h00;
      irq_flags_out  <= 8'h00;
    end else begin
      irq_prev_reg <= stat.i2c_interrupt;
      irq_seen_out <= stat.i2c_interrupt && !irq_prev_reg;
      if (stat.i2c_interrupt && !irq_prev_reg) begin
        irq_master_out <= stat.master_status_flag;
        irq_status_out <= stat.status_register;
        irq_flags_out  <= stat.flag_register;
      end
    end
  end

endmodule

// File: logic/isbr_sync.sv
// Two-stage level synchroniser for device status
`timescale 1ns/10ps
module isbr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule

// File: pkg/isbr_pkg.sv
// Constants and carrier types for the start-reservation host controller
package isbr_pkg;

  // Clock rate of clock_in
  localparam int CLK_MHZ             = 250;
  // Synchroniser depth on every device input
  localparam int SYNC_STAGES         = 2;
  // Fixed extra clocks in the reservation check wait
  localparam int WAIT_EXTRA_CLK      = 4;
  // Longest time until the start-fail flag is valid
  localparam int START_FAIL_WAIT_CLK = 5;
  // Window in which the join acknowledge would fall
  localparam int JOIN_ACK_MIN_CLK    = 4;
  localparam int JOIN_ACK_MAX_CLK    = 80;
  // Line fall time, plain default
  localparam int FALL_TIME_NS        = 100;
  localparam int FALL_CLK            = (FALL_TIME_NS * CLK_MHZ + 999) / 1000;
  // Idle time both lines must stay high, one frame of nine bits
  localparam int BUS_FREE_NS         = 720;
  localparam int BUS_FREE_CLK        = (BUS_FREE_NS * CLK_MHZ + 999) / 1000;
  // Half period of the recovery clock pulses
  localparam int RECOV_HALF_NS       = 2000;
  localparam int RECOV_HALF_CLK      = (RECOV_HALF_NS * CLK_MHZ) / 1000;
  localparam int RECOV_MAX_PULSES    = 16;
  // Counter width
  localparam int CNT_W               = 12;
  localparam int PULSE_W             = 5;

  // Command codes at the user port
  typedef enum logic [2:0] {
    CMD_INIT,
    CMD_JOIN,
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_FREE_CHECK,
    CMD_RECOVER
  } isbr_cmd_t;

  // Outcome of a command
  typedef enum logic [2:0] {
    RES_OK,
    RES_REJECTED,
    RES_RESERVED,
    RES_RESV_DONE,
    RES_TIMEOUT
  } isbr_res_t;

  // Control bits the host drives into the device
  typedef struct packed {
    logic       i2c_enable_bit;
    logic       start_trigger;
    logic       stop_trigger;
    logic       stop_interrupt_enable;
    logic       bus_release_exit;
    logic       reservation_disable;
    logic       start_without_stop_enable;
    logic       ctrl1_write;
    logic       shift_write;
    logic [7:0] shift_data;
  } isbr_ctrl_t;

  // Status the device shows to the host
  typedef struct packed {
    logic       start_detected_flag;
    logic       stop_detected_flag;
    logic       master_status_flag;
    logic       start_fail_flag;
    logic       bus_busy_flag;
    logic       i2c_interrupt;
    logic       start_trigger_pending;
    logic       stop_trigger_pending;
    logic       clock_line_level;
    logic       data_line_level;
    logic       serial_data_pin;
    logic [7:0] status_register;
    logic [7:0] flag_register;
  } isbr_stat_t;

endpackage

// File: tb/isbr_dev_model.sv
// Behavioural model of the controlled bus device
`timescale 1ns/10ps
module isbr_dev_model
  import isbr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  // Bench controls
  input  wire logic       traffic_in,
  input  wire logic       link_clk_in,
  input  wire logic [2:0] stuck_in,
  // Host side
  input  wire isbr_ctrl_t dev_ctrl_in,
  input  wire logic       scl_in,
  input  wire logic       scl_oe_n_in,
  output isbr_stat_t      dev_stat_out
);
  localparam logic [7:0] STAT_VAL = 8'h5a;
  isbr_stat_t s_reg;
  logic       en_reg, trf_reg, scl_reg;
  logic [2:0] pulse_reg;
  // Released clock pin floats high on its pull-up
  wire logic  scl_w = scl_oe_n_in | scl_in;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
      en_reg <= 1'b0;
      trf_reg <= 1'b0;
      scl_reg <= 1'b1;
      pulse_reg <= 3'h0;
    end else begin
      en_reg <= dev_ctrl_in.i2c_enable_bit;
      trf_reg <= traffic_in;
      scl_reg <= scl_w;
      s_reg.stop_trigger_pending <= dev_ctrl_in.stop_trigger;
      if (dev_ctrl_in.i2c_enable_bit && !en_reg) begin
        s_reg.bus_busy_flag <= !dev_ctrl_in.start_without_stop_enable;
        s_reg.start_detected_flag <= traffic_in;
      end
      if (traffic_in && !trf_reg) begin
        s_reg.master_status_flag <= 1'b0;
        s_reg.stop_detected_flag <= 1'b0;
        s_reg.i2c_interrupt <= 1'b0;
      end
      if (dev_ctrl_in.start_trigger) begin
        s_reg.master_status_flag <= !traffic_in;
        s_reg.start_trigger_pending <= traffic_in && !dev_ctrl_in.reservation_disable;
        s_reg.start_fail_flag <= traffic_in && dev_ctrl_in.reservation_disable;
      end
      if ((!traffic_in && trf_reg) || s_reg.stop_trigger_pending) begin
        s_reg.stop_detected_flag <= 1'b1;
        s_reg.bus_busy_flag <= 1'b0;
        s_reg.i2c_interrupt <= dev_ctrl_in.stop_interrupt_enable;
        s_reg.start_trigger_pending <= 1'b0;
        if (s_reg.start_trigger_pending) s_reg.master_status_flag <= 1'b1;
      end
      if (dev_ctrl_in.shift_write && s_reg.stop_detected_flag) s_reg.i2c_interrupt <= 1'b0;
      if (scl_reg && !scl_w && pulse_reg != 3'h7) pulse_reg <= pulse_reg + 3'h1;
    end
  end
  always_comb begin
    dev_stat_out = s_reg;
    dev_stat_out.clock_line_level = !traffic_in || link_clk_in;
    dev_stat_out.serial_data_pin = pulse_reg >= stuck_in;
    dev_stat_out.data_line_level = !traffic_in && pulse_reg >= stuck_in;
    dev_stat_out.status_register = STAT_VAL;
    dev_stat_out.flag_register = ~STAT_VAL;
  end
endmodule

// File: tb/isbr_host_monitor.sv
// Assertion checker bound to the start-reservation host
`timescale 1ns/10ps
module isbr_host_monitor
  import isbr_pkg::*;
(
  // Clock and reset
  input wire logic       clock_in,
  input wire logic       reset_n_in,
  // User side
  input wire logic       cmd_valid_in,
  input wire isbr_cmd_t  cmd_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic       mode_poll_in,
  input wire logic       cmd_ready_out,
  input wire logic       cmd_done_out,
  // Device side
  input wire isbr_ctrl_t dev_ctrl_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  wire logic go = cmd_valid_in && cmd_ready_out;
  wire logic st = dev_ctrl_out.start_trigger;
  a_start_pulse: assert property (st |=> !dev_ctrl_out.start_trigger)
    else $error("start trigger held");
  a_stop_pulse: assert property (dev_ctrl_out.stop_trigger |=> !dev_ctrl_out.stop_trigger)
    else $error("stop trigger held");
  a_write_lat: assert property (go && cmd_in == CMD_WRITE |=> dev_ctrl_out.shift_write
    && dev_ctrl_out.shift_data == $past(cmd_data_in) ##1 cmd_done_out) else $error("write path wrong");
  a_resv_irq: assert property (st && !mode_poll_in |-> dev_ctrl_out.stop_interrupt_enable)
    else $error("stop interrupt not armed");
  a_poll_noirq: assert property (st && mode_poll_in |-> !dev_ctrl_out.stop_interrupt_enable)
    else $error("stop interrupt armed in poll mode");
  a_no_early: assert property (st |=> !dev_ctrl_out.shift_write [*8])
    else $error("address written too early");
  a_fail_wait: assert property (st && dev_ctrl_out.reservation_disable |=> !cmd_done_out [*6])
    else $error("start result taken too early");
  a_rel_exit: assert property (dev_ctrl_out.bus_release_exit |->
    dev_ctrl_out.i2c_enable_bit && !dev_ctrl_out.stop_interrupt_enable) else $error("release exit misplaced");
  a_stop_en: assert property (dev_ctrl_out.stop_trigger |-> dev_ctrl_out.i2c_enable_bit)
    else $error("stop without enable");
  c_start: cover property (go && cmd_in == CMD_START);
  c_join: cover property (dev_ctrl_out.bus_release_exit);
  c_reject: cover property (st && dev_ctrl_out.reservation_disable);
endmodule

bind isbr_host isbr_host_monitor u_isbr_host_monitor (.clock_in, .reset_n_in, .cmd_valid_in, .cmd_in,
  .cmd_data_in, .mode_poll_in, .cmd_ready_out, .cmd_done_out, .dev_ctrl_out);

// File: tb/tb_top.sv
// Self-checking bench for the start-reservation host
`timescale 1ns/10ps
module tb_top;
  import isbr_pkg::*;
  logic       clock_in, reset_n_in, cmd_valid_in, rdis, swos, poll, traffic, link_clk;
  logic       cmd_ready_out, cmd_done_out, irq_seen_out, irq_master_out, scl_out, scl_oe_n_out;
  logic [2:0] stuck;
  logic [7:0] cmd_data_in, low_w, high_w, last_data, a, irq_status_out, irq_flags_out;
  isbr_cmd_t  cmd_in;
  isbr_res_t  cmd_result_out;
  isbr_stat_t stat;
  isbr_ctrl_t ctrl;
  int         n_errors, checked, seed, k, n_irq, cyc, t0;
  isbr_host u_isbr_host (.clock_in(clock_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_data_in(cmd_data_in), .mode_resv_disable_in(rdis), .mode_start_wo_stop_in(swos),
    .mode_poll_in(poll), .low_width_in(low_w), .high_width_in(high_w), .cmd_ready_out(cmd_ready_out),
    .cmd_done_out(cmd_done_out), .cmd_result_out(cmd_result_out), .irq_seen_out(irq_seen_out),
    .irq_master_out(irq_master_out), .irq_status_out(irq_status_out), .irq_flags_out(irq_flags_out),
    .dev_stat_in(stat), .dev_ctrl_out(ctrl), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out));
  isbr_dev_model u_isbr_dev_model (.clock_in(clock_in), .reset_n_in(reset_n_in), .traffic_in(traffic),
    .link_clk_in(link_clk), .stuck_in(stuck), .dev_ctrl_in(ctrl), .scl_in(scl_out),
    .scl_oe_n_in(scl_oe_n_out), .dev_stat_out(stat));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // Bus clock of the other traffic, 80 ns period
  initial begin
    link_clk = 1'b1;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge clock_in) if (ctrl.shift_write === 1'b1) last_data <= ctrl.shift_data;
  // Cycle count and interrupt pulse count for timing checks
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      cyc <= 0;
      n_irq <= 0;
    end else begin
      cyc <= cyc + 1;
      if (irq_seen_out === 1'b1) n_irq <= n_irq + 1;
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic wait_done(input isbr_res_t e);
    int i;
    for (i = 0; i < 6000 && cmd_done_out !== 1'b1; i++) begin
      @(posedge clock_in);
      #1;
    end
    if (cmd_done_out !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED done exp 1 got 0");
      complete_run();
    end else begin
      checked++;
      if (cmd_result_out !== e) begin
        n_errors++;
        $display("CHECK FAILED result exp %0d got %0d", e, cmd_result_out);
      end
      @(posedge clock_in);
      #1;
    end
  endtask
  // Ready is a register, so it is read settled and the next edge takes the request
  task automatic issue(input isbr_cmd_t c, input logic [7:0] d);
    int i;
    cmd_in = c;
    cmd_data_in = d;
    cmd_valid_in = 1'b1;
    for (i = 0; i < 200 && cmd_ready_out !== 1'b1; i++) begin
      @(posedge clock_in);
      #1;
    end
    if (cmd_ready_out !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED ready exp 1 got 0");
      complete_run();
    end else begin
      @(posedge clock_in);
      #1 cmd_valid_in = 1'b0;
    end
  endtask
  task automatic run(input isbr_cmd_t c, input logic [7:0] d, input isbr_res_t e);
    issue(c, d);
    wait_done(e);
  endtask
  initial begin
    seed = 22;
    n_errors = 0;
    checked = 0;
    reset_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = CMD_INIT;
    cmd_data_in = 8'h00;
    {rdis, swos, poll, stuck} = '0;
    traffic = 1'b1;
    low_w = $random(seed) & 8'h0f;
    high_w = $random(seed) & 8'h0f;
    repeat (12) @(posedge clock_in);
    #1 reset_n_in = 1'b1;
    cmp_bit("ready after reset", 1'b1, cmd_ready_out);
    cmp_bit("ctrl idle after reset", 1'b1, ctrl === '0);
    cmp_bit("scl released after reset", 1'b1, scl_oe_n_out);
    run(CMD_JOIN, 8'h00, RES_OK);
    traffic = 1'b0;
    run(CMD_INIT, 8'h00, RES_OK);
    cmp_bit("busy after stop", 1'b0, stat.bus_busy_flag);
    for (k = 0; k < 3; k++) begin
      a = $random(seed);
      run(CMD_WRITE, a, RES_OK);
      cmp_byte("write data", a, last_data);
    end
    a = $random(seed);
    run(CMD_START, a, RES_OK);
    cmp_byte("free start address", a, last_data);
    for (k = 0; k < 2; k++) begin
      poll = k[0];
      traffic = 1'b1;
      a = $random(seed);
      run(CMD_START, a, RES_RESERVED);
      cmp_bit("reserved no address", 1'b1, last_data !== a || a === 8'h00);
      traffic = 1'b0;
      wait_done(RES_RESV_DONE);
      cmp_byte("reserved address", a, last_data);
      if (k == 0) begin
        cmp_bit("irq master", 1'b1, irq_master_out);
        cmp_byte("irq status", 8'h5a, irq_status_out);
        cmp_byte("irq flags", 8'ha5, irq_flags_out);
        cmp_bit("irq seen once", 1'b1, n_irq == 1);
      end
    end
    poll = 1'b0;
    rdis = 1'b1;
    run(CMD_INIT, 8'h00, RES_OK);
    traffic = 1'b1;
    a = last_data;
    run(CMD_START, ~a, RES_REJECTED);
    cmp_byte("rejected no address", a, last_data);
    run(CMD_STOP, 8'h00, RES_OK);
    cmp_bit("stop detected", 1'b1, stat.stop_detected_flag);
    traffic = 1'b0;
    rdis = 1'b0;
    swos = 1'b1;
    run(CMD_INIT, 8'h00, RES_OK);
    cmp_bit("busy clear at enable", 1'b0, stat.bus_busy_flag);
    traffic = 1'b1;
    issue(CMD_FREE_CHECK, 8'h00);
    repeat (50) @(posedge clock_in);
    #1 traffic = 1'b0;
    t0 = cyc;
    wait_done(RES_OK);
    cmp_bit("free wait length", 1'b1, cyc - t0 >= BUS_FREE_CLK);
    stuck = 3'h3;
    run(CMD_RECOVER, 8'h00, RES_OK);
    cmp_bit("data released", 1'b1, stat.serial_data_pin);
    cmp_bit("scl released", 1'b1, scl_oe_n_out);
    cmp_bit("scl high", 1'b1, scl_out);
    complete_run();
  end
endmodule
